/* rtl/sac_pkg.sv */
// sac_pkg: constants and types shared by both ends of the step attenuator link.
// assumes a 125 MHz host clock; all timing counts except DEV_SETTLE_EDGES (link edges) are derived from it here.
package sac_pkg;

    // attenuation word width
    localparam int ATTEN_W = 6;

    // timing in ns, as specified
    localparam int CLK_PERIOD_NS      = 8;
    localparam int SCLK_MIN_PERIOD_NS = 100;
    localparam int LE_SPACING_NS      = 630;
    localparam int PUP_HOLD_NS        = 1000;

    // derived cycle counts, least times rounded up
    localparam int SCLK_HALF_CYC  = (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam int LE_SPACING_CYC = (LE_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PUP_HOLD_CYC   = (PUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // link edges the device waits before reading the straps
    localparam logic [2:0] DEV_SETTLE_EDGES = 3'h4;

    // preset words: a zero bit adds its step
    localparam logic [ATTEN_W-1:0] PRESET_ATT_31P5 = 6'h00;
    localparam logic [ATTEN_W-1:0] PRESET_ATT_24   = 6'h0F;
    localparam logic [ATTEN_W-1:0] PRESET_ATT_16   = 6'h1F;
    localparam logic [ATTEN_W-1:0] PRESET_ATT_0    = 6'h3F;
    localparam logic [ATTEN_W-1:0] ATTEN_RESET     = 6'h3F;

    // host register map, byte offsets
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_WORD   = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;

    // control fields
    localparam int CTRL_SERIAL_BIT  = 0;
    localparam int CTRL_LATCHED_BIT = 1;
    localparam int CTRL_PSEL_LO_BIT = 2;
    localparam int CTRL_PSEL_HI_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_PUP_BIT   = 1;
    localparam int STAT_ECHO_LSB  = 8;

    // device power-up sequence
    typedef enum logic [1:0] {
        DEV_SETTLE = 2'b00,
        DEV_PRESET = 2'b01,
        DEV_NORMAL = 2'b10
    } sac_dev_state_type;

    // host transfer sequence
    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_SHIFT = 2'b01,
        HST_LATCH = 2'b10
    } sac_hst_state_type;

endpackage : sac_pkg

/* rtl/sac_link_if.sv */
// sac_link_if: control pins between host controller and step attenuator.
// assumes the host generates serial_clock; no pin is two-way.
`timescale 1ns/1ps
interface sac_link_if;
    logic                        serial_clock;
    logic                        serial_in;
    logic                        serial_out;
    logic                        latch_strobe;
    logic                        interface_select;
    logic                        preset_select_lo;
    logic                        preset_select_hi;
    logic [sac_pkg::ATTEN_W-1:0] attenuation_bits;

    modport device (
        input  serial_clock,
        input  serial_in,
        output serial_out,
        input  latch_strobe,
        input  interface_select,
        input  preset_select_lo,
        input  preset_select_hi,
        input  attenuation_bits
    );

    modport host (
        output serial_clock,
        output serial_in,
        input  serial_out,
        output latch_strobe,
        output interface_select,
        output preset_select_lo,
        output preset_select_hi,
        output attenuation_bits
    );
endinterface : sac_link_if

/* rtl/sac_sync.sv */
// sac_sync: three-stage synchroniser for a group of slow levels.
// assumes each bit is a level held far longer than three clock periods.
`timescale 1ns/1ps
module sac_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    ////////////////////////////////////////////////////////////////////////
    // chain; s1 feeds only s2
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // accept a bit only once stage two and three agree
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    sync_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule : sac_sync

/* rtl/sac_device.sv */
// sac_device: control logic of the 6-bit step attenuator, clocked by the link.
// assumes the host launches serial_in and latch_strobe on serial_clock falling
// edges; the slow parallel pins are synchronised here.
`timescale 1ns/1ps
module sac_device (
    // link to the host
    sac_link_if.device                   link,
    // power-up reset
    input  wire logic                    rstn_in,
    // attenuator state
    output logic [sac_pkg::ATTEN_W-1:0]  attenuation_bits_out,
    output logic [sac_pkg::ATTEN_W-1:0]  attenuation_steps_out,
    // status
    output logic                         preset_active_out,
    output logic                         serial_mode_out
);

    localparam int W = sac_pkg::ATTEN_W;

    // synchronised slow pins
    logic [W+2:0] pins_raw;
    logic [W+2:0] pins_sync;
    logic         sel_s;
    logic [1:0]   psel_s;
    logic [W-1:0] par_s;

    // strobe edge
    logic         le_prev_reg;
    logic         le_rise;

    // shift path
    logic [W-1:0] shift_reg;

    // power-up sequence
    sac_pkg::sac_dev_state_type state_reg;
    logic [2:0]   settle_cnt_reg;
    logic         use_table_reg;
    logic [1:0]   table_sel_reg;

    // attenuator state
    logic [W-1:0] att_reg;

    ////////////////////////////////////////////////////////////////////////
    // preset table lookup
    function automatic logic [W-1:0] preset_word(input logic [1:0] sel);
        logic [W-1:0] w;
        case (sel)
            2'h0:    w = sac_pkg::PRESET_ATT_31P5;
            2'h1:    w = sac_pkg::PRESET_ATT_24;
            2'h2:    w = sac_pkg::PRESET_ATT_16;
            default: w = sac_pkg::PRESET_ATT_0;
        endcase
        return w;
    endfunction : preset_word

    ////////////////////////////////////////////////////////////////////////
    // slow pins cross from the host's domain
    assign pins_raw = {link.interface_select,
                       link.preset_select_hi,
                       link.preset_select_lo,
                       link.attenuation_bits};

    sac_sync #(
        .W        (W + 3)
    ) u_pin_sync (
        .clk_in   (link.serial_clock),
        .rstn_in  (rstn_in),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    // unpack
    assign sel_s  = pins_sync[W+2];
    assign psel_s = pins_sync[W+1:W];
    assign par_s  = pins_sync[W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // strobe is launched by the host in step with this clock, so no sync
    always_ff @(posedge link.serial_clock or negedge rstn_in) begin
        if (!rstn_in) begin
            le_prev_reg <= 1'b0;
        end else begin
            le_prev_reg <= link.latch_strobe;
        end
    end

    assign le_rise = link.latch_strobe & ~le_prev_reg;

    ////////////////////////////////////////////////////////////////////////
    // shift register; in parallel mode it mirrors the pins every edge,
    // which stands in for the asynchronous load of a discrete part
    always_ff @(posedge link.serial_clock or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_reg <= sac_pkg::ATTEN_RESET;
        end else if (!sel_s) begin
            shift_reg <= par_s;
        end else if (!link.latch_strobe) begin
            shift_reg <= {shift_reg[W-2:0], link.serial_in};
        end
        // strobe high in serial mode: edges ignored
    end

    // last stage drives the chain output
    assign link.serial_out = shift_reg[W-1];

    ////////////////////////////////////////////////////////////////////////
    // power-up sequence: let the synchroniser fill, catch the straps,
    // then hold the preset until the first strobe pulse
    always_ff @(posedge link.serial_clock or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg      <= sac_pkg::DEV_SETTLE;
            settle_cnt_reg <= 3'h0;
            use_table_reg  <= 1'b0;
            table_sel_reg  <= 2'h0;
        end else begin
            case (state_reg)
                sac_pkg::DEV_SETTLE: begin
                    settle_cnt_reg <= settle_cnt_reg + 3'h1;
                    // the synchroniser output first holds the pins after the
                    // fourth edge, so the straps are read at the fifth
                    if (settle_cnt_reg == sac_pkg::DEV_SETTLE_EDGES) begin
                        // table only for parallel with strobe low
                        use_table_reg <= ~sel_s & ~link.latch_strobe;
                        table_sel_reg <= psel_s;
                        state_reg     <= sac_pkg::DEV_PRESET;
                    end
                end
                sac_pkg::DEV_PRESET: begin
                    if (le_rise) begin
                        state_reg <= sac_pkg::DEV_NORMAL;
                    end
                end
                sac_pkg::DEV_NORMAL: begin
                    state_reg <= sac_pkg::DEV_NORMAL; // no way back before reset
                end
                default: begin
                    state_reg <= sac_pkg::DEV_SETTLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // attenuator state
    always_ff @(posedge link.serial_clock or negedge rstn_in) begin
        if (!rstn_in) begin
            att_reg <= sac_pkg::ATTEN_RESET;
        end else begin
            case (state_reg)
                sac_pkg::DEV_SETTLE: begin
                    att_reg <= sac_pkg::ATTEN_RESET;
                end
                sac_pkg::DEV_PRESET: begin
                    if (le_rise) begin
                        // the first pulse already acts normally
                        att_reg <= sel_s ? shift_reg : par_s;
                    end else if (use_table_reg) begin
                        att_reg <= preset_word(table_sel_reg);
                    end else begin
                        // serial with strobe high has no defined preset;
                        // following the pins was chosen for it too
                        att_reg <= par_s;
                    end
                end
                default: begin
                    if (sel_s) begin
                        if (le_rise) begin
                            att_reg <= shift_reg;
                        end
                    end else if (link.latch_strobe) begin
                        // strobe held high gives direct mode,
                        // a pulse gives latched mode
                        att_reg <= par_s;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; steps count 0.5 dB units, a zero bit adds attenuation
    assign attenuation_bits_out  = att_reg;
    assign attenuation_steps_out = ~att_reg;
    assign preset_active_out     = (state_reg != sac_pkg::DEV_NORMAL);
    assign serial_mode_out       = sel_s;

endmodule : sac_device

/* rtl/sac_host.sv */
// sac_host: host controller that drives the attenuator pins.
// assumes an APB master on mclk_in; the link clock is made here by a divider.
`timescale 1ns/1ps
module sac_host (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // link to the device
    sac_link_if.host         link
);

    localparam int W = sac_pkg::ATTEN_W;

    // registers
    logic [3:0]   ctrl_reg;
    logic [W-1:0] word_reg;
    logic         go_reg;
    logic [31:0]  prdata_reg;
    logic         err_reg;
    logic         busy;
    logic         wr_word;

    // divider and timers
    logic [3:0]   div_cnt_reg;
    logic         sclk_reg;
    logic         fall_tick;
    logic [6:0]   pup_cnt_reg;
    logic         pup_done;
    logic [6:0]   gap_cnt_reg;
    logic         gap_load;

    // pins and sequence
    sac_pkg::sac_hst_state_type state_reg;
    logic         sel_reg;
    logic [1:0]   psel_reg;
    logic [W-1:0] bits_reg;
    logic         sin_reg;
    logic         le_reg;
    logic [W-1:0] word_sh_reg;
    logic [2:0]   bits_left_reg;
    logic         sout_s;
    logic [W-1:0] echo_reg;
    logic         mode_change;

    ////////////////////////////////////////////////////////////////////////
    // apb: decode at setup, answer in access with zero wait
    assign busy    = go_reg | (state_reg != sac_pkg::HST_IDLE);
    assign wr_word = psel_in & penable_in & pwrite_in & ~err_reg & (paddr_in == sac_pkg::REG_WORD);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else if (psel_in && !penable_in) begin
            err_reg    <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            case (paddr_in)
                sac_pkg::REG_CTRL:   prdata_reg[3:0] <= ctrl_reg;
                sac_pkg::REG_WORD: begin
                    prdata_reg[W-1:0] <= word_reg;
                    err_reg           <= pwrite_in & busy; // refuse while sending
                end
                sac_pkg::REG_STATUS: begin
                    prdata_reg[sac_pkg::STAT_BUSY_BIT] <= busy;
                    prdata_reg[sac_pkg::STAT_PUP_BIT]  <= pup_done;
                    prdata_reg[sac_pkg::STAT_ECHO_LSB +: W] <= echo_reg;
                end
                default:             err_reg <= 1'b1;
            endcase
        end
    end

    assign pready_out  = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & err_reg;
    assign prdata_out  = prdata_reg;

    // control and word registers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_reg <= sac_pkg::CTRL_RESET;
            word_reg <= sac_pkg::ATTEN_RESET;
        end else if (psel_in && penable_in && pwrite_in && !err_reg) begin
            if (paddr_in == sac_pkg::REG_CTRL) begin
                ctrl_reg <= pwdata_in[3:0];
            end
            if (paddr_in == sac_pkg::REG_WORD) begin
                word_reg <= pwdata_in[W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free-running link clock; 7 + 7 cycles = 112 ns meets the minimum
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt_reg <= 4'h0;
            sclk_reg    <= 1'b0;
        end else if (div_cnt_reg == 4'(sac_pkg::SCLK_HALF_CYC - 1)) begin
            div_cnt_reg <= 4'h0;
            sclk_reg    <= ~sclk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    // pins change only at falling edges, half a period before sampling
    assign fall_tick = sclk_reg & (div_cnt_reg == 4'(sac_pkg::SCLK_HALF_CYC - 1));

    // hold every pin except serial_clock for the power-up time
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pup_cnt_reg <= 7'h00;
        end else if (!pup_done) begin
            pup_cnt_reg <= pup_cnt_reg + 7'h01;
        end
    end

    assign pup_done = (pup_cnt_reg == 7'(sac_pkg::PUP_HOLD_CYC));

    // strobe spacing, also lets the device resync after a mode change
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gap_cnt_reg <= 7'h00;
        end else if (gap_load) begin
            gap_cnt_reg <= 7'(sac_pkg::LE_SPACING_CYC);
        end else if (gap_cnt_reg != 7'h00) begin
            gap_cnt_reg <= gap_cnt_reg - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequence
    assign mode_change = (sel_reg != ctrl_reg[sac_pkg::CTRL_SERIAL_BIT]) ||
                         (psel_reg != {ctrl_reg[sac_pkg::CTRL_PSEL_HI_BIT], ctrl_reg[sac_pkg::CTRL_PSEL_LO_BIT]});
    assign gap_load    = fall_tick & pup_done & (gap_cnt_reg == 7'h00) & (state_reg == sac_pkg::HST_IDLE) &
                         (mode_change | (go_reg & ~ctrl_reg[sac_pkg::CTRL_SERIAL_BIT]));

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg     <= sac_pkg::HST_IDLE;
            go_reg        <= 1'b0;
            sel_reg       <= 1'b0;
            psel_reg      <= 2'h0;
            bits_reg      <= sac_pkg::ATTEN_RESET;
            sin_reg       <= 1'b0;
            le_reg        <= 1'b0;
            word_sh_reg   <= sac_pkg::ATTEN_RESET;
            bits_left_reg <= 3'h0;
        end else begin
            if (wr_word) begin
                go_reg <= 1'b1;
            end
            if (fall_tick) begin
                case (state_reg)
                    sac_pkg::HST_IDLE: begin
                        if (!pup_done || gap_cnt_reg != 7'h00) begin
                            state_reg <= sac_pkg::HST_IDLE;
                        end else if (mode_change) begin
                            sel_reg  <= ctrl_reg[sac_pkg::CTRL_SERIAL_BIT];
                            psel_reg <= {ctrl_reg[sac_pkg::CTRL_PSEL_HI_BIT], ctrl_reg[sac_pkg::CTRL_PSEL_LO_BIT]};
                            le_reg   <= 1'b0;
                        end else if (go_reg) begin
                            go_reg <= 1'b0;
                            if (sel_reg) begin
                                // msb goes out first
                                sin_reg       <= word_reg[W-1];
                                word_sh_reg   <= {word_reg[W-2:0], 1'b0};
                                bits_left_reg <= 3'(W - 1);
                                state_reg     <= sac_pkg::HST_SHIFT;
                            end else begin
                                // bits go out first and the strobe six falls later,
                                // once the device's synchroniser holds the new bits
                                bits_reg      <= word_reg;
                                bits_left_reg <= 3'(W - 1);
                                state_reg     <= sac_pkg::HST_SHIFT;
                            end
                        end
                    end
                    sac_pkg::HST_SHIFT: begin
                        if (bits_left_reg == 3'h0) begin
                            le_reg    <= 1'b1;
                            state_reg <= sac_pkg::HST_LATCH;
                        end else begin
                            sin_reg       <= word_sh_reg[W-1];
                            word_sh_reg   <= {word_sh_reg[W-2:0], 1'b0};
                            bits_left_reg <= bits_left_reg - 3'h1;
                        end
                    end
                    sac_pkg::HST_LATCH: begin
                        // direct parallel keeps the strobe high, the other modes pulse it
                        le_reg    <= ~sel_reg & ~ctrl_reg[sac_pkg::CTRL_LATCHED_BIT];
                        state_reg <= sac_pkg::HST_IDLE;
                    end
                    default: begin
                        state_reg <= sac_pkg::HST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chain echo: last six bits returned while shifting
    sac_sync #(
        .W        (1)
    ) u_echo_sync (
        .clk_in   (mclk_in),
        .rstn_in  (rstn_in),
        .async_in (link.serial_out),
        .sync_out (sout_s)
    );

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            echo_reg <= '0;
        end else if (fall_tick && state_reg == sac_pkg::HST_SHIFT && sel_reg) begin
            echo_reg <= {echo_reg[W-2:0], sout_s};
        end
    end

    // pins
    assign link.serial_clock     = sclk_reg;
    assign link.serial_in        = sin_reg;
    assign link.latch_strobe     = le_reg;
    assign link.interface_select = sel_reg;
    assign link.preset_select_lo = psel_reg[0];
    assign link.preset_select_hi = psel_reg[1];
    assign link.attenuation_bits = bits_reg;

endmodule : sac_host

/* verification/sac_link_props.sv */
// sac_link_props: assertions on the link pins between host and device.
// assumes it is placed beside the link interface and clocked by its serial clock.
`timescale 1ns/1ps
module sac_link_props (
    // link pins
    input wire logic                        serial_clock,
    input wire logic                        serial_in,
    input wire logic                        serial_out,
    input wire logic                        latch_strobe,
    input wire logic                        interface_select,
    input wire logic [sac_pkg::ATTEN_W-1:0] attenuation_bits,
    // device reset
    input wire logic                        rstn_in
);
////////////////////////////////////////
    default clocking cb @(posedge serial_clock); endclocking
    default disable iff (!rstn_in);
    // select passes a synchroniser, so shifting is trusted only after it settles
    sequence s_shift;
        (interface_select && !latch_strobe)[*8] ##1 (interface_select && !latch_strobe)[*3];
    endsequence
    a_echo_delay: assert property (s_shift |-> serial_out == $past(serial_in, 6))
        else $error("echo not six clocks late");
    a_strobe_pulse: assert property ($rose(latch_strobe) && interface_select |=> !latch_strobe)
        else $error("serial strobe too long");
    a_strobe_gap: assert property ($rose(latch_strobe) |=> (!$rose(latch_strobe))[*5])
        else $error("strobes too close");
    a_word_bits: assert property ($rose(latch_strobe) && interface_select |-> !$past(latch_strobe, 6))
        else $error("strobe before six bits");
    a_shift_masked: assert property (interface_select && $past(interface_select, 4) && $past(latch_strobe)
        |-> $stable(serial_out)) else $error("shift while strobe high");
    a_par_load: assert property ((!interface_select && $stable(attenuation_bits))[*8]
        |-> serial_out == attenuation_bits[5]) else $error("no parallel load");
    a_power_hold: assert property ($rose(rstn_in)
        |-> ($stable({latch_strobe, interface_select, attenuation_bits}))[*3]) else $error("pins moved");
    a_preset_low: assert property ($rose(rstn_in) |-> (!latch_strobe)[*4])
        else $error("strobe high at power-up");
endmodule : sac_link_props

/* verification/tb_top.sv */
// tb_top: host and device joined by the link; the host is driven over apb.
// assumes the rtl files are compiled first; the host makes the link clock.
`timescale 1ns/1ps
module tb_top;
    logic        mclk_in = 1'b0, rstn_in = 1'b0, dev_rstn = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic        pwrite_in = 1'b0, pready_out, pslverr_out, qe, pre, smode;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, q;
    logic [5:0]  att, stp;
    int          error_cnt = 0, n_tests = 0;
    sac_link_if link ();
    sac_host i_sac_host (.mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .link(link.host));
    sac_device i_sac_device (.link(link.device), .rstn_in(dev_rstn), .attenuation_bits_out(att),
        .attenuation_steps_out(stp), .preset_active_out(pre), .serial_mode_out(smode));
    sac_link_props i_sac_link_props (.serial_clock(link.serial_clock), .serial_in(link.serial_in),
        .serial_out(link.serial_out), .latch_strobe(link.latch_strobe), .rstn_in(dev_rstn),
        .interface_select(link.interface_select), .attenuation_bits(link.attenuation_bits));
////////////////////////////////////////
    // 125 MHz clock
    initial forever #4 mclk_in = ~mclk_in;
    // compare and count
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    // one apb transfer; read data lands in q, error flag in qe
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        {q, qe} = {prdata_out, pslverr_out};
        {psel_in, penable_in} <= 2'b00;
    endtask : apb
    // poll busy under a bound, then let the device's sync settle
    task idle;
        q = 32'h1;
        for (int i = 0; i < 300 && q[0] !== 1'b0; i++) apb(1'b0, 12'h008, 32'h0);
        repeat (6) @(posedge link.serial_clock);
    endtask : idle
    // each strap code with a device power-up
    task t_preset;
        logic [5:0] tbl [4] = '{6'h00, 6'h0F, 6'h1F, 6'h3F};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 32'(i) << 2);
            repeat (12) @(posedge link.serial_clock);
            dev_rstn <= 1'b0;
            repeat (3) @(posedge link.serial_clock);
            dev_rstn <= 1'b1;
            repeat (8) @(posedge link.serial_clock);
            chk({25'h0, pre, att}, {25'h1, tbl[i]});
        end
        $display("preset done");
    endtask : t_preset
    // serial words back to back; the write made while busy must be refused;
    // the free link clock fills the chain with the held last bit, so the echo
    // of the second frame is five ones of the first word's lsb, then the second word's msb
    task t_serial;
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h004, 32'h2B);
        idle();
        chk({24'h0, pre, smode, att}, 32'h6B);
        apb(1'b1, 12'h004, 32'h15);
        apb(1'b1, 12'h004, 32'h3C);
        chk({31'h0, qe}, 32'h1);
        apb(1'b1, 12'hFFC, 32'h0);
        idle();
        apb(1'b0, 12'h008, 32'h0);
        chk({20'h0, q[13:8], stp}, {20'h0, 6'h3E, 6'h2A});
        $display("serial done");
    endtask : t_serial
    // latched then direct parallel
    task t_par;
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b1, 12'h004, 32'h33);
        idle();
        chk({25'h0, smode, att}, 32'h33);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0C);
        idle();
        chk({26'h0, stp}, 32'h33);
        $display("parallel done");
    endtask : t_par
    // verdict
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // host out of reset first, the device once the link clock runs
    initial begin
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge link.serial_clock);
        dev_rstn <= 1'b1;
        repeat (130) @(posedge mclk_in);
        t_preset();
        t_serial();
        t_par();
        stop_test();
    end
    // watchdog, far beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule : tb_top
